//--- lcd_port_pkg.sv
// Package of constants and types for the character display port
package lcd_port_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;

  // Register byte offsets within the port window
  localparam logic [0:0] OFS_DISPLAY_COMMAND = 1'h0;
  localparam logic [0:0] OFS_DISPLAY_CHARACTER = 1'h1;

  // Command byte fields
  localparam int unsigned CURSOR_SET_FLAG_BIT = 7;
  localparam int unsigned ROW_BIT = 6;

  // Location addressing
  localparam logic [6:0] TOP_ROW_BASE = 7'h00;
  localparam logic [6:0] BOTTOM_ROW_BASE = 7'h40;
  localparam int unsigned ROW_LENGTH = 40;
  localparam int unsigned VISIBLE_LENGTH = 16;

  // Display commands
  localparam logic [7:0] CMD_CLEAR = 8'h01;
  localparam logic [7:0] CMD_CURSOR_OFF = 8'h0C;
  localparam logic [7:0] CMD_CURSOR_BLINK = 8'h0F;
  localparam logic [7:0] CMD_SHIFT_LEFT = 8'h18;
  localparam logic [7:0] CMD_SHIFT_RIGHT = 8'h1C;
  localparam logic [7:0] CMD_FUNC_SET = 8'h38;
  localparam logic [7:0] CMD_ENTRY_MODE = 8'h06;
  localparam logic [7:0] CMD_HOME = 8'h80;

  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Timing in nanoseconds, converted to cycles (least times round up)
  localparam int unsigned T_POWER_NS = 15_000_000;
  localparam int unsigned T_SETUP_NS = 60;
  localparam int unsigned T_PULSE_NS = 460;
  localparam int unsigned T_HOLD_NS = 40;
  localparam int unsigned T_EXEC_NS = 40_000;
  localparam int unsigned T_CLEAR_NS = 1_640_000;
  localparam int unsigned NS_PER_CYCLE = 1_000_000_000 / CLK_HZ;
  localparam int unsigned CYC_POWER = (T_POWER_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int unsigned CYC_SETUP = (T_SETUP_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int unsigned CYC_PULSE = (T_PULSE_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int unsigned CYC_HOLD = (T_HOLD_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int unsigned CYC_EXEC = (T_EXEC_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int unsigned CYC_CLEAR = (T_CLEAR_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;

  localparam int unsigned INIT_STEPS = 4;

  typedef enum logic [3:0] {
    CYC_IDLE = 4'b0001,
    CYC_SETUP_ST = 4'b0010,
    CYC_PULSE_ST = 4'b0100,
    CYC_HOLD_ST = 4'b1000
  } cycle_state_t;

  typedef enum logic [3:0] {
    TOP_POWER = 4'b0001,
    TOP_INIT = 4'b0010,
    TOP_READY = 4'b0100,
    TOP_WAIT = 4'b1000
  } top_state_t;

  function automatic logic is_slow_command(input logic is_char, input logic [7:0] b);
    is_slow_command = !is_char && (b == CMD_CLEAR || b[7:1] == 7'h01);
  endfunction

endpackage

//--- lcd_xfer_if.sv
// Interface between the port sequencer and the bus cycle engine
`timescale 1ns/100ps
`default_nettype none
interface lcd_xfer_if;
  logic start;
  logic is_char;
  logic [7:0] byte_val;
  logic slow;
  logic done;
  modport seq (output start, output is_char, output byte_val, output slow, input done);
  modport eng (input start, input is_char, input byte_val, input slow, output done);
endinterface
`default_nettype wire

//--- lcd_cycle.sv
// Display bus write cycle engine with execution wait
`timescale 1ns/100ps
`default_nettype none
module lcd_cycle (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  lcd_xfer_if.eng x,
  output logic LCD_RS,
  output logic LCD_EN,
  output logic [7:0] LCD_DATA
);
  import lcd_port_pkg::*;

  localparam int unsigned CNT_W = 17;

  cycle_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] wait_q;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_q <= CYC_IDLE;
      cnt_q <= '0;
      wait_q <= '0;
      LCD_RS <= 1'b0;
      LCD_EN <= 1'b0;
      LCD_DATA <= BYTE_RESET;
    end else begin
      case (state_q)
        CYC_IDLE: begin
          if (x.start) begin
            LCD_RS <= x.is_char;
            LCD_DATA <= x.byte_val;
            wait_q <= x.slow ? CNT_W'(CYC_CLEAR) : CNT_W'(CYC_EXEC);
            cnt_q <= CNT_W'(CYC_SETUP);
            state_q <= CYC_SETUP_ST;
          end
        end
        CYC_SETUP_ST: begin
          if (cnt_q <= CNT_W'(1)) begin
            LCD_EN <= 1'b1;
            cnt_q <= CNT_W'(CYC_PULSE);
            state_q <= CYC_PULSE_ST;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        CYC_PULSE_ST: begin
          if (cnt_q <= CNT_W'(1)) begin
            LCD_EN <= 1'b0;
            cnt_q <= CNT_W'(CYC_HOLD) + wait_q;
            state_q <= CYC_HOLD_ST;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        CYC_HOLD_ST: begin
          if (cnt_q <= CNT_W'(1)) begin
            state_q <= CYC_IDLE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        default: state_q <= CYC_IDLE;
      endcase
    end
  end

  assign x.done = (state_q == CYC_HOLD_ST) && (cnt_q <= CNT_W'(1));

  ////////////////////////////////////////////////////////////////
  property p_en_after_setup;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (state_q == CYC_IDLE && x.start) |-> ##(CYC_SETUP + 1) LCD_EN;
  endproperty
  a_en_after_setup: assert property (p_en_after_setup) else $error("enable not raised after setup");

  property p_data_stable;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (state_q != CYC_IDLE) |=> $stable(LCD_DATA) && $stable(LCD_RS);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("bus changed during cycle");
endmodule
`default_nettype wire

//--- char_lcd_port.sv
// Processor port for a 16x2 character display
// How it works
// - Reset runs display init without software
// - Location address: row bit, six column bits
// - Top row at 00, bottom at 40
// - Command and character registers reach display
`timescale 1ns/100ps
`default_nettype none
module char_lcd_port #(
  parameter int unsigned POWER_CYCLES = lcd_port_pkg::CYC_POWER
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [0:0] ADDR,
  input wire logic WRITE,
  input wire logic [7:0] WRITEDATA,
  output logic WAITREQUEST,
  output logic LCD_RS,
  output logic LCD_EN,
  output logic LCD_RW,
  output logic LCD_ON,
  output logic [7:0] LCD_DATA,
  output logic INIT_DONE,
  output logic [6:0] CURSOR_LOCATION
);
  import lcd_port_pkg::*;

  localparam int unsigned PW = 20;

  lcd_xfer_if xf ();

  top_state_t state_q;
  logic [PW-1:0] power_q;
  logic [1:0] step_q;
  logic start_q;
  logic is_char_q;
  logic [7:0] byte_q;
  logic [6:0] cursor_q;
  logic init_done_q;
  logic accept;

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] init_byte(input logic [1:0] idx);
    case (idx)
      2'd0: init_byte = CMD_FUNC_SET;
      2'd1: init_byte = CMD_CURSOR_BLINK;
      2'd2: init_byte = CMD_CLEAR;
      default: init_byte = CMD_ENTRY_MODE;
    endcase
  endfunction

  function automatic logic [6:0] next_location(input logic [6:0] loc);
    if (loc[5:0] == 6'(ROW_LENGTH - 1)) begin
      next_location = loc[ROW_BIT] ? TOP_ROW_BASE : BOTTOM_ROW_BASE;
    end else begin
      next_location = loc + 7'h01;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Processor writes held off until init is done and the engine is free
  assign accept = WRITE && (state_q == TOP_READY);
  assign WAITREQUEST = WRITE && !accept;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_q <= TOP_POWER;
      power_q <= '0;
      step_q <= 2'd0;
      start_q <= 1'b0;
      is_char_q <= 1'b0;
      byte_q <= BYTE_RESET;
      init_done_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        TOP_POWER: begin
          if (power_q >= PW'(POWER_CYCLES - 1)) begin
            state_q <= TOP_INIT;
            start_q <= 1'b1;
            is_char_q <= 1'b0;
            byte_q <= init_byte(2'd0);
          end else begin
            power_q <= power_q + PW'(1);
          end
        end
        TOP_INIT: begin
          if (xf.done) begin
            if (step_q == 2'(INIT_STEPS - 1)) begin
              state_q <= TOP_READY;
              init_done_q <= 1'b1;
            end else begin
              step_q <= step_q + 2'd1;
              start_q <= 1'b1;
              byte_q <= init_byte(step_q + 2'd1);
            end
          end
        end
        TOP_READY: begin
          if (accept) begin
            start_q <= 1'b1;
            is_char_q <= (ADDR == OFS_DISPLAY_CHARACTER);
            byte_q <= WRITEDATA;
            state_q <= TOP_WAIT;
          end
        end
        TOP_WAIT: begin
          if (xf.done) begin
            state_q <= TOP_READY;
          end
        end
        default: state_q <= TOP_POWER;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shadow of the display cursor for status
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cursor_q <= TOP_ROW_BASE;
    end else if (accept) begin
      if (ADDR == OFS_DISPLAY_CHARACTER) begin
        cursor_q <= next_location(cursor_q);
      end else if (WRITEDATA[CURSOR_SET_FLAG_BIT]) begin
        cursor_q <= WRITEDATA[6:0];
      end else if (WRITEDATA == CMD_CLEAR) begin
        cursor_q <= TOP_ROW_BASE;
      end
    end
  end

  assign xf.start = start_q;
  assign xf.is_char = is_char_q;
  assign xf.byte_val = byte_q;
  assign xf.slow = is_slow_command(is_char_q, byte_q);

  lcd_cycle u_cycle (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .x(xf.eng),
    .LCD_RS(LCD_RS),
    .LCD_EN(LCD_EN),
    .LCD_DATA(LCD_DATA)
  );

  assign LCD_RW = 1'b0;
  assign LCD_ON = 1'b1;
  assign INIT_DONE = init_done_q;
  assign CURSOR_LOCATION = cursor_q;

  ////////////////////////////////////////////////////////////////
  property p_no_accept_before_init;
    @(posedge CLK_SYS) disable iff (!RST_N)
      !init_done_q |-> !accept;
  endproperty
  a_no_accept_before_init: assert property (p_no_accept_before_init) else $error("write taken during init");

  property p_stall_while_busy;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (state_q == TOP_WAIT && WRITE) |-> WAITREQUEST;
  endproperty
  a_stall_while_busy: assert property (p_stall_while_busy) else $error("write not stalled while busy");

  property p_char_goes_rs;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (accept && ADDR == OFS_DISPLAY_CHARACTER) |=> is_char_q && start_q && byte_q == $past(WRITEDATA);
  endproperty
  a_char_goes_rs: assert property (p_char_goes_rs) else $error("character not forwarded");

  property p_cmd_forward;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (accept && ADDR == OFS_DISPLAY_COMMAND) |=> !is_char_q && start_q;
  endproperty
  a_cmd_forward: assert property (p_cmd_forward) else $error("command not forwarded");

  property p_cursor_set;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (accept && ADDR == OFS_DISPLAY_COMMAND && WRITEDATA[7]) |=> cursor_q == $past(WRITEDATA[6:0]);
  endproperty
  a_cursor_set: assert property (p_cursor_set) else $error("cursor not set");

  property p_wrap_bottom;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (accept && ADDR == OFS_DISPLAY_CHARACTER && cursor_q == 7'h27) |=> cursor_q == BOTTOM_ROW_BASE;
  endproperty
  a_wrap_bottom: assert property (p_wrap_bottom) else $error("no move to bottom row");

  property p_clear_home;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (accept && ADDR == OFS_DISPLAY_COMMAND && WRITEDATA == CMD_CLEAR) |=> cursor_q == TOP_ROW_BASE;
  endproperty
  a_clear_home: assert property (p_clear_home) else $error("clear did not home");

  property p_wrap_top;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (accept && ADDR == OFS_DISPLAY_CHARACTER && cursor_q == 7'h67) |=> cursor_q == TOP_ROW_BASE;
  endproperty
  a_wrap_top: assert property (p_wrap_top) else $error("no wrap to top row");

  property p_init_done_holds;
    @(posedge CLK_SYS) disable iff (!RST_N)
      init_done_q |=> init_done_q;
  endproperty
  a_init_done_holds: assert property (p_init_done_holds) else $error("init done dropped");

  property p_wait_until_done;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (state_q == TOP_WAIT && !xf.done) |=> state_q == TOP_WAIT;
  endproperty
  a_wait_until_done: assert property (p_wait_until_done) else $error("left wait early");

  property p_cmd_byte;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (accept && ADDR == OFS_DISPLAY_COMMAND) |=> byte_q == $past(WRITEDATA);
  endproperty
  a_cmd_byte: assert property (p_cmd_byte) else $error("command byte not forwarded");
endmodule
`default_nettype wire

//--- lcd_display_model.sv
// Behavioural model of the 16x2 character display module
`timescale 1ns/100ps
`default_nettype none
module lcd_display_model (
  input wire logic LCD_RS,
  input wire logic LCD_EN,
  input wire logic [7:0] LCD_DATA,
  output logic [6:0] cur,
  output logic blink,
  output int cnt
);
  logic [7:0] mem [0:127];
  logic [7:0] log_b [0:15];
  logic armed = 1'b0;
  logic [7:0] t;
  int b;
  initial begin
    cur = 7'h00;
    blink = 1'b0;
    cnt = 0;
  end
  ////////////////////////////////////////////////////////////
  // Only a real strobe pulse counts, not the reset settling
  always @(posedge LCD_EN) armed = 1'b1;
  always @(negedge LCD_EN) begin
    if (armed) begin
      armed = 1'b0;
      if (cnt < 16) log_b[cnt] = LCD_DATA;
      cnt = cnt + 1;
      if (LCD_RS) begin
        mem[cur] = LCD_DATA;
        cur = (cur[5:0] == 6'd39) ? {~cur[6], 6'h00} : cur + 7'h01;
      end else if (LCD_DATA[7]) begin
        cur = LCD_DATA[6:0];
      end else if (LCD_DATA == 8'h01) begin
        for (int i = 0; i < 128; i++) mem[i] = 8'h20;
        cur = 7'h00;
      end else if (LCD_DATA == 8'h18 || LCD_DATA == 8'h1C) begin
        for (b = 0; b < 128; b += 64) begin
          if (LCD_DATA[2]) begin
            t = mem[b + 39];
            for (int i = 39; i > 0; i--) mem[b + i] = mem[b + i - 1];
            mem[b] = t;
          end else begin
            t = mem[b];
            for (int i = 0; i < 39; i++) mem[b + i] = mem[b + i + 1];
            mem[b + 39] = t;
          end
        end
      end else if (LCD_DATA == 8'h0C || LCD_DATA == 8'h0F) begin
        blink = LCD_DATA[1];
      end
    end
  end
endmodule
`default_nettype wire

//--- tb_char_lcd_port.sv
// Self-checking testbench for the character display port
`timescale 1ns/100ps
`default_nettype none
module tb_char_lcd_port;
  import lcd_port_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [0:0] addr = 1'b0;
  logic write = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic waitrequest, lcd_rs, lcd_en, lcd_rw, lcd_on, init_done, m_blink;
  logic [7:0] lcd_data;
  logic [6:0] cursor, m_cur;
  logic [7:0] init_seq [4] = '{8'h38, 8'h0F, 8'h01, 8'h06};
  int m_cnt;
  int errors = 0;
  int total_checks = 0;

  char_lcd_port #(.POWER_CYCLES(10)) i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr), .WRITE(write),
    .WRITEDATA(wdata), .WAITREQUEST(waitrequest), .LCD_RS(lcd_rs), .LCD_EN(lcd_en), .LCD_RW(lcd_rw),
    .LCD_ON(lcd_on), .LCD_DATA(lcd_data), .INIT_DONE(init_done), .CURSOR_LOCATION(cursor));
  lcd_display_model i_lcd (.LCD_RS(lcd_rs), .LCD_EN(lcd_en), .LCD_DATA(lcd_data), .cur(m_cur),
    .blink(m_blink), .cnt(m_cnt));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Write held until accepted, then the strobe width is measured
  task automatic wr(input logic [0:0] a, input logic [7:0] d);
    int k;
    int n;
    @(posedge clk_sys);
    #1;
    addr = a;
    wdata = d;
    write = 1'b1;
    @(negedge clk_sys);
    while (waitrequest !== 1'b0) @(negedge clk_sys);
    @(posedge clk_sys);
    #1;
    write = 1'b0;
    k = 0;
    while (lcd_en !== 1'b1 && k < 100) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    n = 0;
    while (lcd_en === 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("en_width", 8'(n), 8'(CYC_PULSE));
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_init;
    @(posedge clk_sys);
    #1;
    wdata = 8'hE7;
    write = 1'b1;
    repeat (50) @(posedge clk_sys);
    check("stall", {7'h00, waitrequest}, 8'h01);
    check("init_done", {7'h00, init_done}, 8'h00);
    wr(1'b0, 8'hE7);
    for (int i = 0; i < 4; i++) check("init_seq", i_lcd.log_b[i], init_seq[i]);
    check("command", i_lcd.log_b[4], 8'hE7);
    check("model_cursor", {1'b0, m_cur}, 8'h67);
    check("cursor", {1'b0, cursor}, 8'h67);
    check("blink", {7'h00, m_blink}, 8'h01);
    check("rw_on", {6'h00, lcd_rw, lcd_on}, 8'h01);
    check("init_done", {7'h00, init_done}, 8'h01);
  endtask

  task automatic t_wrap;
    wr(1'b1, 8'h41);
    check("mem67", i_lcd.mem[7'h67], 8'h41);
    check("rs", {7'h00, lcd_rs}, 8'h01);
    check("wrap", {1'b0, m_cur}, 8'h00);
    check("cursor", {1'b0, cursor}, 8'h00);
    wr(1'b1, 8'h42);
    check("mem00", i_lcd.mem[0], 8'h42);
    check("cursor", {1'b0, cursor}, 8'h01);
    wr(1'b0, 8'hA7);
    wr(1'b1, 8'h43);
    check("mem27", i_lcd.mem[7'h27], 8'h43);
    check("bottom", {1'b0, m_cur}, 8'h40);
    check("cursor", {1'b0, cursor}, 8'h40);
  endtask

  task automatic t_shift;
    wr(1'b0, 8'h18);
    check("rotate", i_lcd.mem[7'h27], 8'h42);
    check("shift_top", i_lcd.mem[7'h26], 8'h43);
    check("shift", i_lcd.mem[7'h66], 8'h41);
    check("cursor", {1'b0, cursor}, 8'h40);
    wr(1'b0, 8'h0C);
    check("blink", {7'h00, m_blink}, 8'h00);
    check("rs", {7'h00, lcd_rs}, 8'h00);
    check("transfers", 8'(m_cnt), 8'h0B);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_init();
    t_wrap();
    t_shift();
    stop_test();
  end

  // Init with its clear takes about 88k cycles, the rest about 12k
  initial begin
    #(2_100_000);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
